// ### fdc_status_reset_mode_ctrl.sv
`timescale 1ns/10ps
module fdc_status_reset_mode_ctrl
  import fdc_srm_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic power_on_in,
  input wire logic outreg_wr_in,
  input wire logic outreg_reset_bit_in,
  input wire logic outreg_dma_en_in,
  input wire logic dsr_wr_in,
  input wire logic dsr_reset_in,
  input wire logic dsr_powerdown_in,
  input wire logic cfg3_wr_in,
  input wire logic [7:0] cfg3_data_in,
  input wire logic specify_wr_in,
  input wire logic specify_dma_in,
  input wire logic configure_wr_in,
  input wire logic configure_poll_dis_in,
  input wire logic configure_fifo_en_in,
  input wire logic cmd_start_in,
  input wire fdc_srm_pkg::sector_event_t sector_ev_in,
  input wire logic [7:0] cylinder_in,
  input wire fdc_srm_pkg::drive_pins_t drive_pins_in,
  input wire logic result_phase_in,
  input wire logic result_rd_in,
  input wire logic result_sel_in,
  input wire logic xfer_active_in,
  input wire logic read_cmd_in,
  input wire logic fifo_service_in,
  input wire logic dack_in,
  input wire logic dma_verify_in,
  input wire logic int_req_in,
  input wire logic terminal_count_pin_in,
  input wire logic density_hi_in,
  output logic [7:0] result_data_out,
  output logic core_reset_out,
  output logic outreg_reset_bit_out,
  output logic powerdown_out,
  output logic polling_en_out,
  output logic fifo_en_out,
  output fdc_srm_pkg::mode_t mode_out,
  output logic terminal_count_out,
  output logic density_select_out,
  output logic floppy_interrupt_out,
  output logic floppy_interrupt_oe_out,
  output logic floppy_dma_request_out,
  output logic floppy_dma_request_oe_out,
  output logic fifo_access_out,
  output logic pseudo_read_out
);
  import fdc_srm_pkg::*;

  // ------------------------------------------------------------
  // reset sources
  // ------------------------------------------------------------
  logic outreg_rst_r;
  logic dsr_rst_r;
  logic core_rst;
  logic spec_dma_r;
  logic outreg_dma_r;
  logic [7:0] cfg3_r;
  mode_t mode_nxt;
  logic [7:0] st2;
  logic [7:0] st3_r;

  // any source holds the core in reset
  assign core_rst = rst_in || outreg_rst_r || dsr_rst_r;

  // output register reset bit: pin reset sets it, host clears it
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      outreg_rst_r <= 1'b1;
    else if (outreg_wr_in)
      outreg_rst_r <= outreg_reset_bit_in;
  end

  // rate register reset bit lasts one cycle then clears itself
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      dsr_rst_r <= 1'b0;
    else
      dsr_rst_r <= dsr_wr_in && dsr_reset_in;
  end

  // registered copy of reset state for software and the core
  always_ff @(posedge sys_clk_in)
  begin
    core_reset_out <= core_rst;
    outreg_reset_bit_out <= rst_in || outreg_rst_r;
  end

  // powerdown: any reset wakes the controller
  always_ff @(posedge sys_clk_in)
  begin
    if (core_rst)
      powerdown_out <= 1'b0;
    else if (dsr_wr_in)
      powerdown_out <= dsr_powerdown_in;
  end

  // ------------------------------------------------------------
  // configuration state
  // ------------------------------------------------------------

  // specify values survive the pin reset; only power-on clears them
  always_ff @(posedge sys_clk_in)
  begin
    if (power_on_in)
      spec_dma_r <= 1'b0;
    else if (specify_wr_in && !core_rst)
      spec_dma_r <= specify_dma_in;
  end

  // configure parameters cleared by every reset; polling back on
  always_ff @(posedge sys_clk_in)
  begin
    if (core_rst)
    begin
      polling_en_out <= POLL_RESET;
      fifo_en_out <= FIFO_EN_RESET;
    end
    else if (configure_wr_in)
    begin
      polling_en_out <= !configure_poll_dis_in;
      fifo_en_out <= configure_fifo_en_in;
    end
  end

  // output register dma bit and configuration register three
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      outreg_dma_r <= 1'b0;
      cfg3_r <= CFG3_RESET;
    end
    else
    begin
      if (outreg_wr_in)
        outreg_dma_r <= outreg_dma_en_in;
      if (cfg3_wr_in)
        cfg3_r <= cfg3_data_in;
    end
  end

  // ------------------------------------------------------------
  // operating mode
  // ------------------------------------------------------------
  always_comb
  begin
    if (cfg3_r[CFG3_SEL_STD_BIT])
      mode_nxt = MODE_STD;
    else if (cfg3_r[CFG3_SEL_ENC_BIT])
      mode_nxt = MODE_ALT;
    else
      mode_nxt = MODE_RED;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      mode_out <= MODE_STD;
    else
      mode_out <= mode_nxt;
  end

  // polarity of terminal count and density select per mode
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      terminal_count_out <= 1'b0;
      density_select_out <= DENSITY_PIN_RESET;
    end
    else
    begin
      unique case (mode_out)
        MODE_STD:
        begin
          terminal_count_out <= terminal_count_pin_in;
          density_select_out <= density_hi_in;
        end
        MODE_ALT:
        begin
          terminal_count_out <= !terminal_count_pin_in;
          density_select_out <= !density_hi_in;
        end
        MODE_RED:
        begin
          terminal_count_out <= terminal_count_pin_in;
          density_select_out <= !density_hi_in;
        end
      endcase
    end
  end

  // pin drivers: alternate mode always drives, others follow dma bit
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      floppy_interrupt_oe_out <= 1'b0;
      floppy_dma_request_oe_out <= 1'b0;
    end
    else
    begin
      floppy_interrupt_oe_out <= (mode_out == MODE_ALT) || outreg_dma_r;
      floppy_dma_request_oe_out <= (mode_out == MODE_ALT) || outreg_dma_r;
    end
  end

  // ------------------------------------------------------------
  // dma and interrupt
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (core_rst)
    begin
      floppy_interrupt_out <= 1'b0;
      floppy_dma_request_out <= 1'b0;
      fifo_access_out <= 1'b0;
      pseudo_read_out <= 1'b0;
    end
    else
    begin
      floppy_interrupt_out <= int_req_in;
      floppy_dma_request_out <= spec_dma_r && xfer_active_in && fifo_service_in;
      fifo_access_out <= spec_dma_r && xfer_active_in && dack_in && !dma_verify_in;
      pseudo_read_out <= dack_in && dma_verify_in && !fifo_en_out && read_cmd_in;
    end
  end

  // ------------------------------------------------------------
  // status bytes
  // ------------------------------------------------------------
  status_two_collect #(
    .CYL_W(8)
  ) u_st2 (
    .sys_clk_in(sys_clk_in),
    .core_rst_in(core_rst),
    .cmd_start_in(cmd_start_in),
    .ev_in(sector_ev_in),
    .cyl_in(cylinder_in),
    .st2_out(st2)
  );

  // status three samples the pins every cycle, one cycle late; core reset holds it at ST3_ONES
  always_ff @(posedge sys_clk_in)
  begin
    if (core_rst)
      st3_r <= ST3_ONES;
    else
      st3_r <= {1'b0, drive_pins_in.write_protect, 1'b1, drive_pins_in.track_zero_input, 1'b1,
                drive_pins_in.head_select_output, drive_pins_in.drive_select_field};
  end

  // result phase read of the data register
  always_ff @(posedge sys_clk_in)
  begin
    if (core_rst)
      result_data_out <= 8'h00;
    else if (result_phase_in && result_rd_in)
      result_data_out <= result_sel_in ? st3_r : st2;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_st2_zeros: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st2[7] == 1'b0 && st2[3:2] == 2'b00)
    else $error("status two fixed bits not zero");
  a_st3_fixed: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !core_rst |=> st3_r[7] == 1'b0 && st3_r[5] && st3_r[3])
    else $error("status three fixed bits wrong");
  a_st3_pins: assert property (@(posedge sys_clk_in) disable iff (core_rst)
    !core_rst |=> st3_r[6] == $past(drive_pins_in.write_protect)
      && st3_r[4] == $past(drive_pins_in.track_zero_input)
      && st3_r[2] == $past(drive_pins_in.head_select_output)
      && st3_r[1:0] == $past(drive_pins_in.drive_select_field))
    else $error("status three not mirroring pins");
  a_pin_sets_outreg: assert property (@(posedge sys_clk_in)
    rst_in ##1 !rst_in && !outreg_wr_in |=> outreg_rst_r)
    else $error("pin reset did not hold output reset bit");
  a_dsr_clears: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    dsr_rst_r && !dsr_wr_in |=> !dsr_rst_r)
    else $error("rate reset did not clear itself");
  a_reset_wakes: assert property (@(posedge sys_clk_in)
    core_rst |=> !powerdown_out)
    else $error("reset left powerdown set");
  a_poll_on: assert property (@(posedge sys_clk_in)
    core_rst ##1 !core_rst && !configure_wr_in |=> polling_en_out && !fifo_en_out)
    else $error("polling not restarted after reset");
  a_alt_driven: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    mode_out == MODE_ALT |=> floppy_interrupt_oe_out && floppy_dma_request_oe_out)
    else $error("alternate mode left pins floating");
  a_pseudo_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    pseudo_read_out |-> !$past(fifo_en_out) && $past(read_cmd_in))
    else $error("pseudo read with fifo on or no read");
  a_dma_specify: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    floppy_dma_request_out |-> $past(spec_dma_r))
    else $error("dma request without specify enable");

  c_soft_reset: cover property (@(posedge sys_clk_in) dsr_rst_r ##1 !core_rst);
  c_alt_mode: cover property (@(posedge sys_clk_in) mode_out == MODE_ALT);
  c_result_read: cover property (@(posedge sys_clk_in) result_phase_in && result_rd_in && st2 != 8'h00);
  c_pseudo: cover property (@(posedge sys_clk_in) pseudo_read_out);

endmodule // fdc_status_reset_mode_ctrl

// ### fdc_srm_pkg.sv
// How it works
// - control mark when address mark type mismatches
// - data field crc failure sets bit five
// - id cylinder differs from tracked cylinder
// - mismatch and cylinder ff marks bad track
// - missing data address mark sets bit zero
// - fixed zero bits in status two, three
// - bits five and three of three read one
// - status three mirrors drive pins and selects
// - three reset sources, all leave powerdown
// - reset aborts, clears configure, awaits command
// - polling enabled again after every reset
// - pin reset spares specify values only
// - pin reset sets output reset bit
// - rate reset self clears, output reset wins
// - both soft resets clear core identically
// - mode from configuration three bits six, five
// - standard mode: dma bit valid, active high
// - alternate: pins always driven, active low
// - reduced: dma bit valid, mixed polarity
// - specify dma raises request, acknowledge accesses
// - verify pseudo read needs fifo off, read
// - status bytes returned during result phase
package fdc_srm_pkg;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST2_CM_BIT = 6;
  localparam int ST2_CRC_ERR_BIT = 5;
  localparam int ST2_WRONG_CYL_BIT = 4;
  localparam int ST2_BAD_CYL_BIT = 1;
  localparam int ST2_NO_MARK_BIT = 0;
  localparam int CFG3_SEL_STD_BIT = 6;
  localparam int CFG3_SEL_ENC_BIT = 5;
  localparam logic [7:0] BAD_TRACK_CYL = 8'hFF;
  localparam logic [7:0] ST3_ONES = 8'h28;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG3_RESET = 8'h40;
  localparam logic [7:0] ST2_RESET = 8'h00;
  localparam logic POLL_RESET = 1'b1;
  localparam logic FIFO_EN_RESET = 1'b0;
  localparam logic DENSITY_PIN_RESET = 1'b1;

  // operating modes
  typedef enum logic [2:0] {
    MODE_STD = 3'b001,
    MODE_ALT = 3'b010,
    MODE_RED = 3'b100
  } mode_t;

  // events from the sector engine
  typedef struct packed {
    logic read_deleted_cmd;
    logic mark_seen;
    logic mark_deleted;
    logic crc_fail;
    logic id_valid;
    logic [7:0] id_cyl;
    logic no_mark;
  } sector_event_t;

  // drive side levels reported in status three
  typedef struct packed {
    logic write_protect;
    logic track_zero_input;
    logic head_select_output;
    logic [1:0] drive_select_field;
  } drive_pins_t;

endpackage

// ### status_two_collect.sv
`timescale 1ns/10ps
module status_two_collect
  import fdc_srm_pkg::*;
#(
  parameter int CYL_W = 8
)(
  input wire logic sys_clk_in,
  input wire logic core_rst_in,
  input wire logic cmd_start_in,
  input wire fdc_srm_pkg::sector_event_t ev_in,
  input wire logic [CYL_W-1:0] cyl_in,
  output logic [7:0] st2_out
);
  import fdc_srm_pkg::*;

  generate
    if (CYL_W != 8)
    begin : g_chk
      $error("status_two_collect: cylinder width must be 8");
    end
  endgenerate

  logic [7:0] set_nxt;
  logic cyl_mismatch;

  // ------------------------------------------------------------
  // event decode
  // ------------------------------------------------------------
  always_comb
  begin
    cyl_mismatch = ev_in.id_valid && (ev_in.id_cyl != cyl_in);
    set_nxt = 8'h00;
    set_nxt[ST2_CM_BIT] = ev_in.mark_seen && (ev_in.mark_deleted != ev_in.read_deleted_cmd);
    set_nxt[ST2_CRC_ERR_BIT] = ev_in.crc_fail;
    set_nxt[ST2_WRONG_CYL_BIT] = cyl_mismatch;
    set_nxt[ST2_BAD_CYL_BIT] = cyl_mismatch && (ev_in.id_cyl == BAD_TRACK_CYL);
    set_nxt[ST2_NO_MARK_BIT] = ev_in.no_mark;
  end

  // sticky flags; new command clears, same-cycle event still lands
  always_ff @(posedge sys_clk_in)
  begin
    if (core_rst_in)
      st2_out <= ST2_RESET;
    else if (cmd_start_in)
      st2_out <= set_nxt;
    else
      st2_out <= st2_out | set_nxt;
  end

  a_cm_mark: assert property (@(posedge sys_clk_in) disable iff (core_rst_in)
    ev_in.mark_seen && (ev_in.mark_deleted != ev_in.read_deleted_cmd) |=> st2_out[ST2_CM_BIT])
    else $error("control mark not set");
  a_bad_track: assert property (@(posedge sys_clk_in) disable iff (core_rst_in)
    st2_out[ST2_BAD_CYL_BIT] |-> st2_out[ST2_WRONG_CYL_BIT])
    else $error("bad track without wrong cylinder");
  a_fresh_cmd: assert property (@(posedge sys_clk_in) disable iff (core_rst_in)
    cmd_start_in && !ev_in.crc_fail |=> !st2_out[ST2_CRC_ERR_BIT])
    else $error("stale crc flag after new command");

endmodule // status_two_collect

// ### dma_ctrl_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// dma controller seen from the system bus
// ----------------------------------------
module dma_ctrl_model
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic drq_in,
  input wire logic [3:0] lat_in,
  output logic dack_out
);
  logic [3:0] wait_r;
  // acknowledge, with specify dma, a transfer active and no verify, grants fifo access, after lat_in cycles of request
  always @(negedge sys_clk_in)
  begin
    if (rst_in || !drq_in)
    begin
      wait_r <= 4'h0;
      dack_out <= 1'b0;
    end
    else if (wait_r < lat_in)
      wait_r <= wait_r + 4'h1;
    else
      dack_out <= 1'b1;
  end
endmodule // dma_ctrl_model

// ### testbench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t mismatch got %h want %h", $time, a, b); end end
module testbench;
  import fdc_srm_pkg::*;
  logic clk, rst, pon, ow_wr, ow_bit, ow_dma, dsr_wr, dsr_rst, dsr_pd;
  logic cfg3_wr, spec_wr, spec_dma, conf_wr, poll_dis, fifo_en, cmd_start;
  logic ph, rd, sel, xfer, rdcmd, svc, dack, verify, intq, tcpin, dhi, rd_d;
  logic [7:0] cfg3, cyl, rdata, exp_b;
  logic [3:0] lat;
  sector_event_t sev;
  drive_pins_t pins;
  mode_t mode;
  logic core_rst, ow_rb, pd, poll, fen, term_cnt, dens, fi, fi_oe, drq, drq_oe;
  logic facc, pread;
  int err_total, check_count, n;
  logic [7:0] q[$];
  fdc_status_reset_mode_ctrl i_dut (.sys_clk_in(clk), .rst_in(rst),
    .power_on_in(pon), .outreg_wr_in(ow_wr), .outreg_reset_bit_in(ow_bit),
    .outreg_dma_en_in(ow_dma), .dsr_wr_in(dsr_wr), .dsr_reset_in(dsr_rst),
    .dsr_powerdown_in(dsr_pd), .cfg3_wr_in(cfg3_wr), .cfg3_data_in(cfg3),
    .specify_wr_in(spec_wr), .specify_dma_in(spec_dma),
    .configure_wr_in(conf_wr), .configure_poll_dis_in(poll_dis),
    .configure_fifo_en_in(fifo_en), .cmd_start_in(cmd_start),
    .sector_ev_in(sev), .cylinder_in(cyl), .drive_pins_in(pins),
    .result_phase_in(ph), .result_rd_in(rd), .result_sel_in(sel),
    .xfer_active_in(xfer), .read_cmd_in(rdcmd), .fifo_service_in(svc),
    .dack_in(dack), .dma_verify_in(verify), .int_req_in(intq),
    .terminal_count_pin_in(tcpin), .density_hi_in(dhi),
    .result_data_out(rdata), .core_reset_out(core_rst),
    .outreg_reset_bit_out(ow_rb), .powerdown_out(pd), .polling_en_out(poll),
    .fifo_en_out(fen), .mode_out(mode), .terminal_count_out(term_cnt),
    .density_select_out(dens), .floppy_interrupt_out(fi),
    .floppy_interrupt_oe_out(fi_oe), .floppy_dma_request_out(drq),
    .floppy_dma_request_oe_out(drq_oe), .fifo_access_out(facc),
    .pseudo_read_out(pread));
  dma_ctrl_model i_dma (.sys_clk_in(clk), .rst_in(rst), .drq_in(drq),
    .lat_in(lat), .dack_out(dack));
  // ----------------------------------------
  // clock, closing and watchdog
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #400000;
    err_total++;
    tally_and_finish();
  end
  // result monitor takes the oldest note per read
  always @(posedge clk)
    rd_d <= rd & ph;
  always @(negedge clk)
  begin
    if (rd_d)
    begin
      exp_b = q.pop_front();
      `CHK(rdata, exp_b)
    end
  end
  // ----------------------------------------
  // stimulus tasks
  // ----------------------------------------
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic rdres(input logic s, input logic [7:0] e);
    q.push_back(e);
    sel = s;
    ph = 1'b1;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
  endtask
  task automatic ev(input sector_event_t e, input logic [7:0] x);
    cmd_start = 1'b1;
    tick(1);
    cmd_start = 1'b0;
    sev = e;
    tick(1);
    sev = '0;
    tick(1);
    rdres(1'b0, x);
  endtask
  task automatic cfg(input logic [7:0] d, input logic m, input logic t, input logic ds);
    cfg3 = d;
    cfg3_wr = 1'b1;
    tick(1);
    cfg3_wr = 1'b0;
    tick(4);
    `CHK(mode, mode_t'({d[6] == 1'b0 && d[5] == 1'b0, d[6] == 1'b0 && d[5], d[6]}))
    `CHK(term_cnt, t)
    `CHK(dens, ds)
    `CHK(drq_oe, m)
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {rst, pon} = 2'b11;
    {ow_wr, ow_bit, ow_dma, dsr_wr, dsr_rst, dsr_pd, cfg3_wr, spec_wr} = '0;
    {spec_dma, conf_wr, poll_dis, fifo_en, cmd_start, ph, rd, sel} = '0;
    {xfer, rdcmd, svc, verify, intq, tcpin, dhi} = '0;
    {cfg3, cyl, lat, sev, pins} = '0;
    err_total = 0;
    check_count = 0;
    void'($urandom(32'h7605_f525));
    tick(10);
    {rst, pon} = 2'b00;
    tick(2);
    `CHK(ow_rb, 1'b1)
    `CHK(core_rst, 1'b1)
    ow_wr = 1'b1;
    tick(1);
    ow_wr = 1'b0;
    tick(2);
    `CHK(core_rst, 1'b0)
    `CHK(poll, 1'b1)
    // status three mirrors random drive pins
    repeat (4)
    begin
      pins = drive_pins_t'(5'($urandom));
      tick(2);
      rdres(1'b1, {1'b0, pins.write_protect, 1'b1, pins.track_zero_input, 1'b1,
        pins.head_select_output, pins.drive_select_field});
    end
    // status two flags, each command starting clean
    cyl = 8'($urandom_range(0, 200));
    ev({1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0}, 8'h40);
    ev({1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 1'b0}, 8'h40);
    ev({1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 1'b0}, 8'h20);
    ev({1'b0, 1'b0, 1'b0, 1'b0, 1'b1, cyl + 8'h01, 1'b0}, 8'h10);
    ev({1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'hff, 1'b0}, 8'h12);
    ev({1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 1'b1}, 8'h01);
    // all three modes with pins asserted internally
    {tcpin, dhi} = 2'b11;
    cfg(8'h20, 1'b1, 1'b0, 1'b0);
    cfg(8'h00, 1'b0, 1'b1, 1'b0);
    cfg(8'h60, 1'b0, 1'b1, 1'b1);
    // output register dma bit now enables both pin drivers
    {ow_wr, ow_dma} = 2'b11;
    tick(1);
    ow_wr = 1'b0;
    tick(2);
    `CHK({fi_oe, drq_oe}, 2'b11)
    // configure, then rate reset clears it and leaves powerdown
    {conf_wr, poll_dis, fifo_en, intq} = 4'b1111;
    tick(1);
    conf_wr = 1'b0;
    tick(2);
    `CHK({poll, fen, fi}, 3'b011)
    {dsr_wr, dsr_rst, dsr_pd} = 3'b101;
    tick(1);
    `CHK(pd, 1'b1)
    dsr_rst = 1'b1;
    tick(1);
    dsr_wr = 1'b0;
    n = 0;
    repeat (6)
    begin
      n += int'(core_rst);
      if (core_rst)
        `CHK(fi, 1'b0)
      tick(1);
    end
    `CHK(n, 1)
    `CHK({poll, fen, pd, fi}, 4'b1001)
    // dma request, acknowledge access, then verify pseudo read
    {spec_wr, spec_dma, xfer, svc} = 4'b1111;
    lat = 4'(3);
    tick(1);
    spec_wr = 1'b0;
    tick(2);
    `CHK(drq, 1'b1)
    tick(4);
    `CHK(facc, 1'b1)
    {verify, rdcmd} = 2'b11;
    tick(2);
    `CHK({pread, facc}, 2'b10)
    tally_and_finish();
  end
endmodule // testbench
